// >>> hdl/payload_header_suppression.v
// payload header suppression engine with apb rule table
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "phs_defines.vh"
module payload_header_suppression (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire in_valid,
  output reg in_ready,
  input wire [7:0] in_data,
  input wire in_last,
  input wire [5:0] in_class,
  input wire in_mcast,
  input wire [13:0] in_sid,
  output reg out_valid,
  input wire out_ready,
  output reg [7:0] out_data,
  output reg out_last
);
  localparam ST_IDLE = 4'd0;
  localparam ST_FILL = 4'd1;
  localparam ST_EH1 = 4'd2;
  localparam ST_EH2 = 4'd3;
  localparam ST_DRAIN = 4'd4;
  localparam ST_PASS = 4'd5;
  localparam ST_RHDR = 4'd6;
  localparam ST_RIDX = 4'd7;
  localparam ST_RDROP = 4'd8;
  localparam ST_RFLD = 4'd9;

  // slot times 48 plus byte, index into the flat template vector
  function [7:0] tb;
    input [1:0] s;
    input [5:0] f;
    begin
      tb = {1'b0, s, 5'b0} + {2'b0, s, 4'b0} + {2'b0, f};
    end
  endfunction

  // lowest set bit of a hit vector
  function [1:0] first_hit;
    input [3:0] v;
    begin
      if (v[0])
        first_hit = 2'd0;
      else if (v[1])
        first_hit = 2'd1;
      else if (v[2])
        first_hit = 2'd2;
      else
        first_hit = 2'd3;
    end
  endfunction

  // --------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------
  reg [2:0] ctrl_reg;
  reg [1:0] sel_reg;
  reg [15:0] err_reg, err_next, sup_reg, sup_next, len_reg, len_next;
  reg [15:0] lcnt_reg, lcnt_next;
  reg [3:0] state_reg, state_next;
  wire wr = psel & penable & pwrite & pready;
  wire twr = wr & (paddr[7:6] == 2'b01) & (paddr[5:2] < `TPL_WORDS);
  wire [`NRULE*8-1:0] idx_w;
  wire [`NRULE*6-1:0] size_w, cls_w;
  wire [`NRULE*14-1:0] sid_w;
  wire [`NRULE*48-1:0] mask_w;
  wire [`NRULE*384-1:0] tpl_w;
  wire [`NRULE-1:0] valid_w, lock_w, vo_w, hit_cls, hit_rx;
  reg [31:0] rd_mux;
  reg mapped;

  // read data and decode for the selected slot
  always @*
  begin
    mapped = 1'b1;
    case (paddr)
      `R_CTRL: rd_mux = {29'h0, ctrl_reg};
      `R_STAT: rd_mux = {16'h0, lock_w, valid_w, 4'h0, state_reg};
      `R_ERR: rd_mux = {16'h0, err_reg};
      `R_SUP: rd_mux = {16'h0, sup_reg};
      `R_SEL: rd_mux = {30'h0, sel_reg};
      `R_CFG: rd_mux = {valid_w[sel_reg], lock_w[sel_reg], 8'h0,
        cls_w[sel_reg*6+:6], 1'b0, vo_w[sel_reg], size_w[sel_reg*6+:6],
        idx_w[sel_reg*8+:8]};
      `R_SID: rd_mux = {18'h0, sid_w[sel_reg*14+:14]};
      `R_MLO: rd_mux = mask_w[sel_reg*48+:32];
      `R_MHI: rd_mux = {16'h0, mask_w[sel_reg*48+32+:16]};
      `R_LEN: rd_mux = {16'h0, len_reg};
      `R_ARM, `R_DEL, `R_CLSDEL: rd_mux = 32'h0;
      default:
      begin
        rd_mux = 32'h0;
        mapped = (paddr[7:6] == 2'b01) & (paddr[5:2] < `TPL_WORDS);
      end
    endcase
  end

  // no wait state: answer prepared in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_reg <= `CTRL_RST;
      sel_reg <= 2'h0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
      if (wr & (paddr == `R_CTRL))
        ctrl_reg <= pwdata[2:0];
      if (wr & (paddr == `R_SEL))
        sel_reg <= pwdata[1:0];
    end
  end

  // --------------------------------------------------------------
  // rule table, one slot per generate step
  // --------------------------------------------------------------
  genvar g, b;
  generate
    for (g = 0; g < `NRULE; g = g + 1)
    begin : g_rule
      reg valid_r, lock_r, vo_r;
      reg [7:0] idx_r;
      reg [5:0] size_r, cls_r;
      reg [13:0] sid_r;
      reg [47:0] mask_r;
      reg [7:0] t [0:47];
      wire me = (sel_reg == g);
      integer j;
      // configuration writes stop once the rule is fully defined
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          valid_r <= 1'b0;
          lock_r <= 1'b0;
          vo_r <= 1'b0;
          idx_r <= 8'h0;
          size_r <= 6'h0;
          cls_r <= 6'h0;
          sid_r <= 14'h0;
          mask_r <= `MASK_RST;
        end
        else
        begin
          if (wr & me & ~lock_r)
          begin
            if (paddr == `R_CFG)
            begin
              idx_r <= pwdata[7:0];
              size_r <= pwdata[`CFG_SIZE+:6];
              vo_r <= pwdata[`CFG_VOFF];
              cls_r <= pwdata[`CFG_CLS+:6];
            end
            if (paddr == `R_SID)
              sid_r <= pwdata[13:0];
            if (paddr == `R_MLO)
              mask_r[31:0] <= pwdata;
            if (paddr == `R_MHI)
              mask_r[47:32] <= pwdata[15:0];
            if ((paddr == `R_ARM) & (size_r != 6'h0) & (size_r <= `MAXB))
            begin
              valid_r <= 1'b1; // unset flag and mask keep defaults
              lock_r <= 1'b1;
            end
          end
          if (wr & ((me & (paddr == `R_DEL)) |
            ((paddr == `R_CLSDEL) & (cls_r == pwdata[5:0]))))
          begin
            valid_r <= 1'b0;
            lock_r <= 1'b0;
            vo_r <= 1'b0;
            mask_r <= `MASK_RST;
          end
        end
      end
      // template bytes, byte lane 0 first in transmission order
      always @(posedge pclk)
      begin
        for (j = 0; j < 4; j = j + 1)
          if (twr & me & ~lock_r)
            t[{paddr[5:2], 2'b00} + j] <= pwdata[j*8+:8];
      end
      for (b = 0; b < 48; b = b + 1)
      begin : g_byte
        assign tpl_w[(g*48+b)*8+:8] = t[b];
      end
      assign valid_w[g] = valid_r;
      assign lock_w[g] = lock_r;
      assign vo_w[g] = vo_r;
      assign idx_w[g*8+:8] = idx_r;
      assign size_w[g*6+:6] = size_r;
      assign cls_w[g*6+:6] = cls_r;
      assign sid_w[g*14+:14] = sid_r;
      assign mask_w[g*48+:48] = mask_r;
      assign hit_cls[g] = valid_r & (cls_r == in_class);
      // downstream ignores the sid
      assign hit_rx[g] = valid_r & (idx_r == in_data) &
        (ctrl_reg[`CTRL_DS] | (sid_r == in_sid));
    end
  endgenerate

  // --------------------------------------------------------------
  // frame path
  // --------------------------------------------------------------
  reg [1:0] slot_reg, slot_next;
  reg [5:0] cnt_reg, cnt_next, rd_reg, rd_next;
  reg mism_reg, mism_next, ok_reg, ok_next, endl_reg, endl_next;
  reg [7:0] buf_reg [0:`BUFN-1];
  reg ov_next, ol_next, rdy_next, emit, e_last, bw_en, mis_now;
  reg [7:0] od_next, e_data;
  reg [5:0] fn;
  wire [5:0] off = ctrl_reg[`CTRL_DS] ? `DS_OFF : `US_OFF;
  wire [5:0] fend = off + size_w[slot_reg*6+:6];
  wire take = in_valid & in_ready;
  wire ofree = ~out_valid | out_ready;
  // field byte position, kept out of the process to avoid a feedback path
  wire [5:0] f = cnt_reg - off;
  wire mbit = (cnt_reg >= off) & mask_w[tb(slot_reg, f)];
  wire rbit = (rd_reg >= off) & mask_w[tb(slot_reg, rd_reg - off)];
  wire [7:0] tbyte = tpl_w[{tb(slot_reg, f), 3'b000}+:8];

  // next state of the suppress and restore machine
  always @*
  begin
    state_next = state_reg;
    slot_next = slot_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    mism_next = mism_reg;
    ok_next = ok_reg;
    endl_next = endl_reg;
    sup_next = sup_reg;
    err_next = err_reg;
    bw_en = 1'b0;
    emit = 1'b0;
    e_data = in_data;
    e_last = in_last;
    mis_now = mbit & ~vo_w[slot_reg] & (in_data != tbyte);
    case (state_reg)
      ST_IDLE:
        if (in_valid)
        begin
          cnt_next = 6'h0;
          rd_next = 6'h0;
          mism_next = 1'b0;
          endl_next = 1'b0;
          slot_next = first_hit(hit_cls);
          if (~ctrl_reg[`CTRL_EN])
            state_next = ST_PASS;
          else if (ctrl_reg[`CTRL_RX])
            state_next = ST_RHDR;
          else if ((|hit_cls) & ~in_mcast)
            state_next = ST_FILL;
          else
            state_next = ST_PASS;
        end
      ST_FILL:
        if (take)
        begin
          bw_en = 1'b1;
          cnt_next = cnt_reg + 6'h1;
          mism_next = mism_reg | mis_now;
          if (in_last)
          begin
            endl_next = 1'b1;
            ok_next = 1'b0;
            state_next = ST_DRAIN;
          end
          else if (cnt_reg + 6'h1 == fend)
          begin
            ok_next = ~(mism_reg | mis_now);
            state_next = (mism_reg | mis_now) ? ST_DRAIN : ST_EH1;
          end
        end
      ST_EH1:
        if (ofree)
        begin
          emit = 1'b1;
          e_data = `EH_TYPE;
          e_last = 1'b0;
          state_next = ST_EH2;
        end
      ST_EH2:
        if (ofree)
        begin
          emit = 1'b1;
          e_data = idx_w[slot_reg*8+:8];
          e_last = 1'b0;
          sup_next = sup_reg + 16'h1;
          state_next = ST_DRAIN;
        end
      ST_DRAIN:
        if ((ok_reg & rbit) | ofree)
        begin
          // after a matched field, masked field bytes are skipped and kept bytes go out; after a mismatch every byte goes out
          emit = ~(ok_reg & rbit);
          e_data = buf_reg[rd_reg];
          e_last = endl_reg & (rd_reg + 6'h1 == cnt_reg);
          rd_next = rd_reg + 6'h1;
          if (rd_reg + 6'h1 == cnt_reg)
            state_next = endl_reg ? ST_IDLE : ST_PASS;
        end
      ST_PASS:
        if (take)
        begin
          emit = 1'b1;
          if (in_last)
            state_next = ST_IDLE;
        end
      ST_RHDR:
        if (take)
        begin
          if (in_data == `EH_TYPE)
            state_next = ST_RIDX;
          else
          begin
            emit = 1'b1;
            state_next = in_last ? ST_IDLE : ST_PASS;
          end
        end
      ST_RIDX:
        if (take)
        begin
          slot_next = first_hit(hit_rx);
          if ((|hit_rx) & ~in_last)
            state_next = ST_RFLD;
          else
          begin
            err_next = err_reg + 16'h1;
            state_next = in_last ? ST_IDLE : ST_RDROP;
          end
        end
      ST_RDROP:
        if (take & in_last)
          state_next = ST_IDLE;
      ST_RFLD:
        if ((mbit & ofree) | (~mbit & take))
        begin
          emit = 1'b1;
          if (mbit)
          begin
            e_data = tbyte;
            e_last = 1'b0;
          end
          cnt_next = cnt_reg + 6'h1;
          if (~mbit & in_last)
            state_next = ST_IDLE;
          else if (cnt_reg + 6'h1 == fend)
            state_next = ST_PASS;
        end
      default: state_next = ST_IDLE;
    endcase
    ov_next = emit | (out_valid & ~out_ready);
    od_next = emit ? e_data : out_data;
    ol_next = emit ? e_last : out_last;
    // output byte count of each frame, after suppression
    lcnt_next = emit ? (e_last ? 16'h0 : lcnt_reg + 16'h1) : lcnt_reg;
    len_next = (emit & e_last) ? lcnt_reg + 16'h1 : len_reg;
    // pass, header and restore states are ready only with a free output slot; fill, index and drop states are not gated by the output
    fn = cnt_next - off;
    case (state_next)
      ST_FILL, ST_RIDX, ST_RDROP: rdy_next = ~(take & in_last & (state_reg == state_next));
      ST_PASS, ST_RHDR: rdy_next = ~ov_next & ~(take & in_last);
      ST_RFLD: rdy_next = ~ov_next &
        ~((cnt_next >= off) & mask_w[tb(slot_next, fn)]);
      default: rdy_next = 1'b0;
    endcase
  end

  // frame path registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      slot_reg <= 2'h0;
      cnt_reg <= 6'h0;
      rd_reg <= 6'h0;
      mism_reg <= 1'b0;
      ok_reg <= 1'b0;
      endl_reg <= 1'b0;
      sup_reg <= 16'h0;
      err_reg <= 16'h0;
      len_reg <= 16'h0;
      lcnt_reg <= 16'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h0;
      out_last <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      mism_reg <= mism_next;
      ok_reg <= ok_next;
      endl_reg <= endl_next;
      sup_reg <= sup_next;
      err_reg <= err_next;
      len_reg <= len_next;
      lcnt_reg <= lcnt_next;
      in_ready <= rdy_next;
      out_valid <= ov_next;
      out_data <= od_next;
      out_last <= ol_next;
    end
  end

  // header hold buffer, filled in arrival order
  always @(posedge pclk)
  begin
    if (bw_en)
      buf_reg[cnt_reg] <= in_data;
  end
endmodule // payload_header_suppression

// >>> hdl/phs_defines.vh
// constants of the payload header suppression engine
`ifndef PHS_DEFINES_VH
`define PHS_DEFINES_VH
// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define R_CTRL 8'h00
`define R_STAT 8'h04
`define R_ERR 8'h08
`define R_SUP 8'h0c
`define R_SEL 8'h10
`define R_CFG 8'h14
`define R_SID 8'h18
`define R_ARM 8'h1c
`define R_DEL 8'h20
`define R_CLSDEL 8'h24
`define R_MLO 8'h28
`define R_MHI 8'h2c
`define R_LEN 8'h30
`define R_TPL 8'h40
`define TPL_WORDS 4'hc
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define CTRL_EN 0
`define CTRL_RX 1
`define CTRL_DS 2
`define CFG_SIZE 8
`define CFG_VOFF 14
`define CFG_CLS 16
`define CFG_LOCK 30
`define CFG_VALID 31
// --------------------------------------------------------------
// sizes, offsets and reset values
// --------------------------------------------------------------
`define NRULE 4
`define MAXB 6'h30
`define US_OFF 6'h00
`define DS_OFF 6'h0c
`define BUFN 60
`define EH_TYPE 8'h71
`define MASK_RST 48'hffffffffffff
`define CTRL_RST 3'h0
`endif

// >>> verif/phs_checker.sv
// concurrent checks on the ports of the header suppression engine
`timescale 1ns/100ps
module phs_checker (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire out_valid,
  input wire out_ready,
  input wire [7:0] out_data,
  input wire out_last
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  property p_setup_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_setup_ready: assert property (p_setup_ready)
    else $error("access cycle missing or too long");
  property p_ready_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without a setup cycle");
  property p_err_with_ready;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error response outside access or with data");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data driven outside access");
  property p_unmapped;
    psel && !penable && paddr == 8'h34 |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  property p_mapped_ok;
    psel && !penable && paddr == 8'h14 |=> pready && !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("rule field access refused");
  // --------------------------------------------------------------
  // output stream
  // --------------------------------------------------------------
  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output byte changed while stalled");
  property p_out_last_once;
    out_valid && out_ready && out_last |=> !(out_valid && out_last && $stable(out_data));
  endproperty
  a_out_last_once: assert property (p_out_last_once)
    else $error("frame end repeated after hand-over");
  c_write: cover property (psel && penable && pready);
  c_refused: cover property (pslverr);
  c_frame_end: cover property (out_valid && out_ready && out_last);
endmodule // phs_checker

bind payload_header_suppression phs_checker chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_last(out_last));

// >>> verif/phs_peer_sink.sv
// peer mac entity that takes the engine's output frames
`timescale 1ns/100ps
module phs_peer_sink (
  input wire pclk,
  input wire presetn,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_last,
  output reg out_ready
);
  logic [1:0] pace_reg;
  logic [7:0] cur_q[$];
  logic [7:0] last_q[$];
  integer frames = 0;
  // stalls one cycle in four, collects whole frames for the bench
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_ready <= 1'b0;
      pace_reg <= 2'h0;
    end
    else
    begin
      pace_reg <= pace_reg + 2'h1;
      out_ready <= (pace_reg != 2'h2);
      if (out_valid && out_ready)
      begin
        cur_q.push_back(out_data);
        if (out_last)
        begin
          last_q = cur_q;
          cur_q = {};
          frames = frames + 1;
        end
      end
    end
  end
endmodule // phs_peer_sink

// >>> verif/testbench.sv
// self-checking testbench for the header suppression engine
`timescale 1ns/100ps
`include "phs_defines.vh"
module testbench;
  typedef logic [7:0] byte_q[$];
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic in_valid = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic in_last = 1'b0;
  logic [5:0] in_class = 6'h00;
  logic in_mcast = 1'b0;
  logic [13:0] in_sid = 14'h155;
  wire [31:0] prdata;
  wire pready, pslverr, in_ready, out_valid, out_ready, out_last;
  wire [7:0] out_data;
  integer seed = 24300;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer k;
  logic [31:0] rd;
  logic err;
  byte_q fr, cf;
  payload_header_suppression uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_last(in_last), .in_class(in_class), .in_mcast(in_mcast), .in_sid(in_sid),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
  phs_peer_sink sink (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
  // --------------------------------------------------------------
  // clock, timeout, report
  // --------------------------------------------------------------
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    $display("compared %0d values, %0d wrong", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // --------------------------------------------------------------
  // bus and stream drivers
  // --------------------------------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task send(input byte_q f, input logic [5:0] cls, input logic mc);
  begin
    @(posedge pclk);
    in_class <= cls;
    in_mcast <= mc;
    foreach (f[i])
    begin
      in_valid <= 1'b1;
      in_data <= f[i];
      in_last <= (i == f.size() - 1);
      @(posedge pclk);
      while (in_ready !== 1'b1)
        @(posedge pclk);
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
  end
  endtask
  task run(input byte_q f, input logic [5:0] cls, input logic mc, input byte_q e);
    integer nf;
    integer n;
  begin
    nf = sink.frames;
    send(f, cls, mc);
    n = 0;
    while (sink.frames == nf && n < 500)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    check(32'(sink.frames - nf), 32'h1);
    check(32'(sink.last_q.size()), 32'(e.size()));
    foreach (e[i])
      check({24'h0, sink.last_q[i]}, {24'h0, e[i]});
  end
  endtask
  task rnd(input integer n);
  begin
    fr = {};
    repeat (n) fr.push_back(8'($random(seed)));
  end
  endtask
  // --------------------------------------------------------------
  // expected frames and rule setup
  // --------------------------------------------------------------
  function automatic logic [7:0] tb(input integer i);
  begin
    return 8'ha0 + i[7:0];
  end
  endfunction
  function automatic byte_q sup(input byte_q f, input logic [7:0] idx, input integer off,
    input integer sz, input logic [47:0] m);
    byte_q r;
  begin
    r = {8'h71, idx};
    foreach (f[i])
      if (i < off || i >= off + sz || !m[i - off])
        r.push_back(f[i]);
    return r;
  end
  endfunction
  function automatic byte_q fill(input byte_q f, input integer off, input integer sz,
    input logic [47:0] m);
  begin
    foreach (f[i])
      if (i >= off && i < off + sz && m[i - off])
        f[i] = tb(i - off);
    return f;
  end
  endfunction
  task rule(input logic [7:0] idx, input logic [5:0] sz, input logic vo, input logic [47:0] m);
  begin
    apb(1'b1, `R_SEL, 32'h0);
    apb(1'b1, `R_CFG, {10'h0, 6'h05, 1'b0, vo, sz, idx});
    apb(1'b1, `R_SID, 32'h155);
    apb(1'b1, `R_MLO, m[31:0]);
    apb(1'b1, `R_MHI, {16'h0, m[47:32]});
    for (k = 0; k < 12; k = k + 1)
      apb(1'b1, 8'(`R_TPL + 4 * k), {tb(4 * k + 3), tb(4 * k + 2), tb(4 * k + 1), tb(4 * k)});
    apb(1'b1, `R_ARM, 32'h0);
  end
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `R_MLO, 32'h0);
    check(rd, 32'hffffffff);
    apb(1'b0, `R_MHI, 32'h0);
    check(rd, 32'h0000ffff);
    apb(1'b0, 8'h34, 32'h0);
    check({rd[30:0], err}, 32'h1);
    rnd(6);
    run(fr, 6'h05, 1'b0, fr);
    $display("reset and pass-through test done");
    rule(8'h5a, 6'h03, 1'b0, 48'h5);
    apb(1'b1, `R_CFG, 32'h0000_0711);
    apb(1'b0, `R_CFG, 32'h0);
    check(rd, {2'b11, 8'h0, 6'h05, 2'b00, 6'h03, 8'h5a});
    apb(1'b1, `R_CTRL, 32'h1);
    for (k = 0; k < 3; k = k + 1)
    begin
      rnd(4 + ($random(seed) & 7));
      fr = fill(fr, 0, 3, 48'h5);
      run(fr, 6'h05, 1'b0, sup(fr, 8'h5a, 0, 3, 48'h5));
    end
    fr[2] = ~fr[2];
    run(fr, 6'h05, 1'b0, fr);
    fr[2] = ~fr[2];
    run(fr, 6'h05, 1'b1, fr);
    apb(1'b0, `R_SUP, 32'h0);
    check(rd, 32'h3);
    $display("suppression test done");
    apb(1'b1, `R_CLSDEL, 32'h5);
    apb(1'b0, `R_STAT, 32'h0);
    check({31'h0, rd[8]}, 32'h0);
    rule(8'h33, 6'h02, 1'b1, 48'h3);
    rnd(7);
    run(fr, 6'h05, 1'b0, sup(fr, 8'h33, 0, 2, 48'h3));
    apb(1'b1, `R_CTRL, 32'h5);
    rnd(16);
    run(fr, 6'h05, 1'b0, sup(fr, 8'h33, 12, 2, 48'h3));
    $display("verify-off and downstream test done");
    apb(1'b1, `R_CTRL, 32'h3);
    rnd(9);
    cf = sup(fr, 8'h33, 0, 2, 48'h3);
    run(cf, 6'h05, 1'b0, fill(fr, 0, 2, 48'h3));
    cf[1] = 8'h34;
    send(cf, 6'h05, 1'b0);
    cf[1] = 8'h33;
    in_sid <= 14'h156;
    send(cf, 6'h05, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, `R_ERR, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, `R_CTRL, 32'h7);
    rnd(16);
    cf = sup(fr, 8'h33, 12, 2, 48'h3);
    run(cf, 6'h05, 1'b0, fill(fr, 12, 2, 48'h3));
    apb(1'b0, `R_LEN, 32'h0);
    check(rd, 32'h10);
    apb(1'b1, `R_DEL, 32'h0);
    apb(1'b1, `R_SEL, 32'h1);
    apb(1'b1, `R_ARM, 32'h0);
    apb(1'b0, `R_STAT, 32'h0);
    check({24'h0, rd[15:8]}, 32'h0);
    $display("restore test done");
    complete_run;
  end
endmodule // testbench
